// ### shared/ucdp_pkg.sv
// Purpose: constants for the charger detect and protect control block
// Assumes: 250 MHz aclk, AXI4-Lite register access
// Notes:   register map offsets are byte addresses
`default_nettype none
package ucdp_pkg;
    localparam int unsigned CLK_MHZ          = 250;
    localparam int unsigned TICK_US          = 1000;
    localparam int unsigned TICK_CYC         = CLK_MHZ * TICK_US;
    localparam int unsigned ATTN_MS          = 1;
    localparam int unsigned PHASE_MS         = 80;
    localparam int unsigned ADDR_W           = 4;
    localparam logic [3:0]  OFF_STATUS       = 4'h0;
    localparam logic [3:0]  OFF_CONFIG       = 4'h4;
    localparam logic [3:0]  OFF_IRQ_STAT     = 4'h8;
    localparam logic [3:0]  OFF_IRQ_EN       = 4'hC;
    localparam int unsigned CFG_GUARD_EN     = 0;
    localparam int unsigned CFG_GUARD_MAN    = 1;
    localparam int unsigned CFG_PATH_ONE     = 2;
    localparam int unsigned CFG_PATH_TWO     = 3;
    localparam int unsigned CFG_EXTENDED     = 4;
    localparam int unsigned CFG_BOTH_HIGH    = 5;
    localparam logic [7:0]  CFG_RESET        = 8'h00;
    localparam logic [2:0]  CLS_NONE         = 3'h0;
    localparam logic [2:0]  CLS_DCP          = 3'h1;
    localparam logic [2:0]  CLS_CDP          = 3'h2;
    localparam logic [2:0]  CLS_SDP          = 3'h3;
    localparam logic [2:0]  CLS_BH_LOW       = 3'h4;
    localparam logic [2:0]  CLS_BH_HIGH      = 3'h5;
    localparam int unsigned IRQ_DONE         = 0;
    localparam int unsigned IRQ_LOCKOUT      = 1;
    localparam int unsigned IRQ_W            = 2;
    localparam logic [1:0]  RESP_OKAY        = 2'h0;
    localparam logic [1:0]  RESP_SLVERR      = 2'h2;
    typedef enum logic [2:0] {
        UCDP_CLS_NONE, UCDP_CLS_DCP, UCDP_CLS_CDP, UCDP_CLS_SDP, UCDP_CLS_BHL, UCDP_CLS_BHH
    } ucdp_class_t;
endpackage
`default_nettype wire

// ### design/ucdp_tick.sv
// Purpose: millisecond enable pulse from aclk
// Assumes: aclk at the package rate
// Notes:   one-cycle pulse each period
`timescale 1ns/1ns
`default_nettype none
module ucdp_tick #(
    parameter int unsigned CYCLES = ucdp_pkg::TICK_CYC
) (
    input  wire logic aclk,
    input  wire logic aresetn,
    output logic      tick
);
    import ucdp_pkg::*;
    logic [31:0] cnt_q;
    wire         wrap = (cnt_q == 32'(CYCLES - 1));
    always_ff @(posedge aclk) begin
        if (!aresetn || wrap) begin
            cnt_q <= 32'h0000_0000;
        end else begin
            cnt_q <= cnt_q + 32'h0000_0001;
        end
    end
    assign tick = wrap;
endmodule // ucdp_tick
`default_nettype wire

// ### design/ucdp_classify.sv
// Purpose: charger detection sequencer, counts phases in ms ticks
// Assumes: line inputs synchronous to aclk
// Notes:   restart pulse reruns the whole sequence
`timescale 1ns/1ns
`default_nettype none
module ucdp_classify #(
    parameter int unsigned PHASE_TICKS = ucdp_pkg::PHASE_MS
) (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       tick,
    input  wire logic       restart,
    input  wire logic       supply_ok,
    input  wire logic [1:0] line_state,
    input  wire logic       data_voltage_raw,
    input  wire logic       dm_reflects_dp,
    input  wire logic       high_current_dm,
    input  wire logic       extended_detect_on,
    input  wire logic       both_high_detect_on,
    output logic            data_voltage_seen,
    output logic            busy,
    output logic            done_pulse,
    output logic [2:0]      port_class_code
);
    import ucdp_pkg::*;
    typedef enum logic [1:0] { ST_IDLE, ST_CONTACT, ST_PROBE, ST_DONE } ucdp_seq_t;
    ucdp_seq_t   st_q;
    logic [7:0]  cnt_q;
    logic [2:0]  code_q;
    wire         phase_end = tick && (cnt_q == 8'(PHASE_TICKS - 1));
    assign data_voltage_seen = data_voltage_raw && (line_state == 2'h0);
    wire         both_high = (line_state == 2'h3) && both_high_detect_on;
    wire [2:0]   verdict = both_high ? (high_current_dm ? CLS_BH_HIGH : CLS_BH_LOW) :
                           !data_voltage_seen ? CLS_SDP :
                           (dm_reflects_dp && extended_detect_on) ? CLS_CDP : CLS_DCP;
    always_ff @(posedge aclk) begin
        done_pulse <= 1'b0;
        if (!aresetn || restart || !supply_ok) begin
            st_q   <= ST_IDLE;
            cnt_q  <= 8'h00;
            code_q <= CLS_NONE;
        end else begin
            case (st_q)
                ST_IDLE: begin
                    st_q <= ST_CONTACT;
                end
                ST_CONTACT, ST_PROBE: begin
                    if (phase_end) begin
                        cnt_q <= 8'h00;
                        if (st_q == ST_CONTACT) begin
                            st_q <= ST_PROBE;
                        end else begin
                            st_q       <= ST_DONE;
                            code_q     <= verdict;
                            done_pulse <= 1'b1;
                        end
                    end else if (tick) begin
                        cnt_q <= cnt_q + 8'h01;
                    end
                end
                ST_DONE: begin
                    st_q <= ST_DONE;
                end
                default: begin
                    st_q <= ST_IDLE;
                end
            endcase
        end
    end
    assign busy            = (st_q != ST_DONE);
    assign port_class_code = code_q;
endmodule // ucdp_classify
`default_nettype wire

// ### design/ucdp_ctrl.sv
// Purpose: supply guard, current limit, mux and attention control with AXI4-Lite registers
// Assumes: comparator and line inputs synchronous to aclk
// Notes:   lockout below low level resets all registers but the AXI4-Lite channel and tick counter
//
// Our own choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module ucdp_ctrl #(
    parameter int unsigned TICK_CYCLES = ucdp_pkg::TICK_CYC,
    parameter int unsigned PHASE_TICKS = ucdp_pkg::PHASE_MS,
    parameter int unsigned ATTN_TICKS  = ucdp_pkg::ATTN_MS
) (
    input  wire logic                          aclk,
    input  wire logic                          aresetn,
    input  wire logic [ucdp_pkg::ADDR_W-1:0]   s_axi_awaddr,
    input  wire logic                          s_axi_awvalid,
    output logic                               s_axi_awready,
    input  wire logic [31:0]                   s_axi_wdata,
    input  wire logic [3:0]                    s_axi_wstrb,
    input  wire logic                          s_axi_wvalid,
    output logic                               s_axi_wready,
    output logic [1:0]                         s_axi_bresp,
    output logic                               s_axi_bvalid,
    input  wire logic                          s_axi_bready,
    input  wire logic [ucdp_pkg::ADDR_W-1:0]   s_axi_araddr,
    input  wire logic                          s_axi_arvalid,
    output logic                               s_axi_arready,
    output logic [31:0]                        s_axi_rdata,
    output logic [1:0]                         s_axi_rresp,
    output logic                               s_axi_rvalid,
    input  wire logic                          s_axi_rready,
    input  wire logic                          low_supply_lockout,
    input  wire logic                          high_supply_lockout,
    input  wire logic [1:0]                    line_state,
    input  wire logic                          data_voltage_raw,
    input  wire logic                          dm_reflects_dp,
    input  wire logic                          high_current_dm,
    output logic                               supply_guard_closed,
    output logic                               current_limit_on,
    output logic                               path_one_on,
    output logic                               path_two_on,
    output logic                               data_voltage_seen,
    output logic                               attention_n,
    output logic                               irq
);
    import ucdp_pkg::*;

    logic        tick;
    logic        busy;
    logic        done_pulse;
    logic [2:0]  port_class_code;
    logic [7:0]  cfg_q;
    logic [IRQ_W-1:0] ist_q;
    logic [IRQ_W-1:0] ien_q;
    logic        attn_q;
    logic [7:0]  attn_cnt_q;
    logic        lock_q;
    logic        aw_held_q;
    logic        w_held_q;
    logic [ADDR_W-1:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0]  w_strb_q;
    logic        bvalid_q;
    logic [1:0]  bresp_q;
    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;

    wire regs_rst_n = aresetn && !low_supply_lockout;
    wire lockout    = low_supply_lockout || high_supply_lockout;

    ucdp_tick #(
        .CYCLES (TICK_CYCLES)
    ) u_tick (
        .aclk    (aclk),
        .aresetn (aresetn),
        .tick    (tick)
    );

    ucdp_classify #(
        .PHASE_TICKS (PHASE_TICKS)
    ) u_classify (
        .aclk                (aclk),
        .aresetn             (regs_rst_n),
        .tick                (tick),
        .restart             (1'b0),
        .supply_ok           (!high_supply_lockout),
        .line_state          (line_state),
        .data_voltage_raw    (data_voltage_raw),
        .dm_reflects_dp      (dm_reflects_dp),
        .high_current_dm     (high_current_dm),
        .extended_detect_on  (cfg_q[CFG_EXTENDED]),
        .both_high_detect_on (cfg_q[CFG_BOTH_HIGH]),
        .data_voltage_seen   (data_voltage_seen),
        .busy                (busy),
        .done_pulse          (done_pulse),
        .port_class_code     (port_class_code)
    );

    // Write channel capture
    wire aw_take   = s_axi_awvalid && !aw_held_q && !bvalid_q;
    wire w_take    = s_axi_wvalid && !w_held_q && !bvalid_q;
    wire aw_have   = aw_held_q || aw_take;
    wire w_have    = w_held_q || w_take;
    wire wr_fire   = aw_have && w_have && !bvalid_q;
    wire [ADDR_W-1:0] wr_addr = aw_held_q ? aw_addr_q : s_axi_awaddr;
    wire [31:0]  wr_data = w_held_q ? w_data_q : s_axi_wdata;
    wire [3:0]   wr_strb = w_held_q ? w_strb_q : s_axi_wstrb;
    wire         wr_lane0 = wr_fire && wr_strb[0];
    wire         wr_cfg   = wr_lane0 && (wr_addr == OFF_CONFIG);
    wire         wr_clr   = wr_lane0 && (wr_addr == OFF_IRQ_STAT);
    wire         wr_ien   = wr_lane0 && (wr_addr == OFF_IRQ_EN);
    wire         wr_hit   = (wr_addr == OFF_CONFIG) || (wr_addr == OFF_IRQ_STAT) || (wr_addr == OFF_IRQ_EN);

    // Read channel
    wire rd_take   = s_axi_arvalid && !rvalid_q;
    wire rd_status = rd_take && (s_axi_araddr == OFF_STATUS);
    wire [31:0] status_word = {24'h000000, port_class_code, !busy, current_limit_on,
                               !supply_guard_closed, lockout, high_supply_lockout};
    wire        rd_hit = (s_axi_araddr == OFF_STATUS) || (s_axi_araddr == OFF_CONFIG) ||
                         (s_axi_araddr == OFF_IRQ_STAT) || (s_axi_araddr == OFF_IRQ_EN);
    wire [31:0] rd_word = (s_axi_araddr == OFF_STATUS)   ? status_word :
                          (s_axi_araddr == OFF_CONFIG)   ? {24'h000000, cfg_q} :
                          (s_axi_araddr == OFF_IRQ_STAT) ? {30'h00000000, ist_q} :
                          (s_axi_araddr == OFF_IRQ_EN)   ? {30'h00000000, ien_q} : 32'h0000_0000;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            aw_addr_q <= 4'h0;
            w_data_q  <= 32'h0000_0000;
            w_strb_q  <= 4'h0;
            bvalid_q  <= 1'b0;
            bresp_q   <= RESP_OKAY;
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h0000_0000;
            rresp_q   <= RESP_OKAY;
        end else begin
            if (wr_fire) begin
                aw_held_q <= 1'b0;
                w_held_q  <= 1'b0;
                bvalid_q  <= 1'b1;
                bresp_q   <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end else begin
                if (aw_take) begin
                    aw_held_q <= 1'b1;
                    aw_addr_q <= s_axi_awaddr;
                end
                if (w_take) begin
                    w_held_q <= 1'b1;
                    w_data_q <= s_axi_wdata;
                    w_strb_q <= s_axi_wstrb;
                end
                if (bvalid_q && s_axi_bready) begin
                    bvalid_q <= 1'b0;
                end
            end
            if (rd_take) begin
                rvalid_q <= 1'b1;
                rdata_q  <= rd_word;
                rresp_q  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!regs_rst_n) begin
            cfg_q <= CFG_RESET;
            ien_q <= '0;
        end else begin
            if (wr_cfg) begin
                cfg_q <= wr_data[7:0];
            end
            if (wr_ien) begin
                ien_q <= wr_data[IRQ_W-1:0];
            end
        end
    end

    // Sticky events, set beats clear
    logic [IRQ_W-1:0] ev_set;
    assign ev_set[IRQ_DONE]    = done_pulse;
    assign ev_set[IRQ_LOCKOUT] = lockout && !lock_q;
    always_ff @(posedge aclk) begin
        if (!regs_rst_n) begin
            ist_q  <= '0;
            lock_q <= 1'b1;
        end else begin
            lock_q <= lockout;
            ist_q  <= (ist_q & ~(wr_clr ? wr_data[IRQ_W-1:0] : '0)) | ev_set;
        end
    end

    wire attn_end = attn_q && ((tick && (attn_cnt_q == 8'(ATTN_TICKS - 1))) || rd_status);
    always_ff @(posedge aclk) begin
        if (!regs_rst_n) begin
            attn_q     <= 1'b0;
            attn_cnt_q <= 8'h00;
        end else if (done_pulse) begin
            attn_q     <= 1'b1;
            attn_cnt_q <= 8'h00;
        end else if (attn_end) begin
            attn_q <= 1'b0;
        end else if (attn_q && tick) begin
            attn_cnt_q <= attn_cnt_q + 8'h01;
        end
    end

    wire guard_on = !lockout && (cfg_q[CFG_GUARD_MAN] ? cfg_q[CFG_GUARD_EN] : 1'b1);
    wire sdp_hold = (port_class_code == CLS_SDP) && !cfg_q[CFG_GUARD_EN];
    wire mux_ok   = !lockout && !busy;
    wire sel_two  = cfg_q[CFG_PATH_TWO] && !cfg_q[CFG_PATH_ONE];

    assign supply_guard_closed = guard_on;
    assign current_limit_on    = !lockout && (busy || sdp_hold);
    assign path_one_on         = mux_ok && !sel_two;
    assign path_two_on         = mux_ok && sel_two;
    assign attention_n         = !attn_q;
    assign irq                 = |(ist_q & ien_q);
    assign s_axi_awready       = !aw_held_q && !bvalid_q;
    assign s_axi_wready        = !w_held_q && !bvalid_q;
    assign s_axi_bvalid        = bvalid_q;
    assign s_axi_bresp         = bresp_q;
    assign s_axi_arready       = !rvalid_q;
    assign s_axi_rvalid        = rvalid_q;
    assign s_axi_rdata         = rdata_q;
    assign s_axi_rresp         = rresp_q;
endmodule // ucdp_ctrl
`default_nettype wire

// ### verification/ucdp_ctrl_sva.sv
// Purpose: port assertions for ucdp_ctrl
// Assumes: one aclk domain
// Notes: bound into every ucdp_ctrl
`timescale 1ns/1ns
`default_nettype none
module ucdp_ctrl_sva #(
    parameter int unsigned TICK_CYCLES = 10,
    parameter int unsigned PHASE_TICKS = 2,
    parameter int unsigned ATTN_TICKS  = 1
) (
    input wire logic                        aclk,
    input wire logic                        aresetn,
    input wire logic [ucdp_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic                        s_axi_arvalid,
    input wire logic                        s_axi_arready,
    input wire logic                        low_supply_lockout,
    input wire logic                        high_supply_lockout,
    input wire logic [1:0]                  line_state,
    input wire logic                        data_voltage_raw,
    input wire logic                        supply_guard_closed,
    input wire logic                        current_limit_on,
    input wire logic                        path_one_on,
    input wire logic                        path_two_on,
    input wire logic                        data_voltage_seen,
    input wire logic                        attention_n,
    input wire logic                        irq
);
    import ucdp_pkg::*;
    localparam int unsigned ATTN_LIM = 2 * ATTN_TICKS * TICK_CYCLES + 4;
    logic        lock;
    logic [15:0] attn_cnt_q;
    logic [15:0] attn_cnt_d;
    assign lock = low_supply_lockout | high_supply_lockout;
    assign attn_cnt_d = attention_n ? 16'h0000 : attn_cnt_q + 16'h0001;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            attn_cnt_q <= 16'h0000;
        end else begin
            attn_cnt_q <= attn_cnt_d;
        end
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_guard_lock; lock |-> !supply_guard_closed; endproperty
    property p_path_lock; lock [*3] |-> !path_one_on && !path_two_on; endproperty
    property p_path_excl; !(path_one_on && path_two_on); endproperty
    property p_path_detect; $fell(low_supply_lockout) |-> (!path_one_on && !path_two_on) [*8]; endproperty
    property p_limit_detect; $fell(low_supply_lockout) |-> ##2 current_limit_on [*6]; endproperty
    property p_dvs_off; (line_state != 2'h0) |-> !data_voltage_seen; endproperty
    property p_dvs_on; (data_voltage_raw && line_state == 2'h0) |-> data_voltage_seen; endproperty
    property p_attn_len; attn_cnt_q <= ATTN_LIM; endproperty
    property p_attn_read;
        (s_axi_arvalid && s_axi_arready && s_axi_araddr == OFF_STATUS && !attention_n) |-> ##[1:3] attention_n;
    endproperty
    property p_lock_reset; low_supply_lockout [*3] |-> attention_n && !irq; endproperty
    a_guard_lock: assert property (p_guard_lock)
        else $error("guard closed in lockout");
    a_path_lock: assert property (p_path_lock)
        else $error("path on in lockout");
    a_path_excl: assert property (p_path_excl)
        else $error("both paths on");
    a_path_detect: assert property (p_path_detect)
        else $error("path on during detection");
    a_limit_detect: assert property (p_limit_detect)
        else $error("limit off during detection");
    a_dvs_off: assert property (p_dvs_off)
        else $error("voltage seen with lines high");
    a_dvs_on: assert property (p_dvs_on)
        else $error("voltage not seen");
    a_attn_len: assert property (p_attn_len)
        else $error("attention held too long");
    a_attn_read: assert property (p_attn_read)
        else $error("attention kept after status read");
    a_lock_reset: assert property (p_lock_reset)
        else $error("outputs not reset in lockout");
    c_done: cover property ($fell(attention_n));
    c_high: cover property ($rose(high_supply_lockout));
    c_irq: cover property ($rose(irq));
endmodule // ucdp_ctrl_sva
bind ucdp_ctrl ucdp_ctrl_sva #(.TICK_CYCLES(TICK_CYCLES), .PHASE_TICKS(PHASE_TICKS), .ATTN_TICKS(ATTN_TICKS)) u_sva (
    .aclk(aclk), .aresetn(aresetn), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .low_supply_lockout(low_supply_lockout),
    .high_supply_lockout(high_supply_lockout), .line_state(line_state), .data_voltage_raw(data_voltage_raw),
    .supply_guard_closed(supply_guard_closed), .current_limit_on(current_limit_on), .path_one_on(path_one_on),
    .path_two_on(path_two_on), .data_voltage_seen(data_voltage_seen), .attention_n(attention_n), .irq(irq)
);
`default_nettype wire

// ### verification/ucdp_port_model.sv
// Purpose: behavioural charger or host on the connector
// Assumes: kind holds the class code to imitate
// Notes: noise mode drives arbitrary line levels
`timescale 1ns/1ns
`default_nettype none
module ucdp_port_model (
    input  wire logic       plugged,
    input  wire logic       over,
    input  wire logic [2:0] kind,
    input  wire logic       noise_en,
    input  wire logic [2:0] noise,
    output logic            low_supply_lockout,
    output logic            high_supply_lockout,
    output logic [1:0]      line_state,
    output logic            data_voltage_raw,
    output logic            dm_reflects_dp,
    output logic            high_current_dm
);
    import ucdp_pkg::*;
    logic se1;
    assign se1 = (kind == CLS_BH_LOW) || (kind == CLS_BH_HIGH);
    // No supply while detached
    assign low_supply_lockout = !plugged;
    assign high_supply_lockout = plugged && over;
    // Pull-downs hold lines low when detached
    assign line_state = noise_en ? noise[1:0] : ((plugged && se1) ? 2'h3 : 2'h0);
    assign data_voltage_raw = noise_en ? noise[2] : (plugged && (kind == CLS_DCP || kind == CLS_CDP));
    assign dm_reflects_dp = plugged && (kind == CLS_CDP);
    assign high_current_dm = plugged && (kind == CLS_BH_HIGH);
endmodule // ucdp_port_model
`default_nettype wire

// ### verification/tb_usb_charger_detect_protect_ctrl.sv
// Purpose: self-checking bench for ucdp_ctrl
// Assumes: short tick and phase counts
// Notes: reads checked by a queue monitor
`timescale 1ns/1ns
`default_nettype none
module tb_usb_charger_detect_protect_ctrl;
    import ucdp_pkg::*;
    typedef struct packed {logic [31:0] d; logic [31:0] m; logic [1:0] r;} ucdp_note_t;
    logic        aclk, awready, wready, bvalid, arready, rvalid, guard, limit, p1, p2, dvs, attn_n, irq;
    logic        lo, hi, raw, refl, hcd;
    logic        aresetn = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic        plugged = 1'h0, over = 1'h0, noise_en = 1'h0;
    logic [1:0]  bresp, rresp, ls;
    logic [2:0]  kind = 3'h0, noise = 3'h0;
    logic [3:0]  awaddr = 4'h0, araddr = 4'h0;
    logic [31:0] wdata = 32'h0, rdata;
    int          err_count = 0, check_count = 0, seed = 86, i;
    ucdp_note_t  cur;
    ucdp_note_t  note_q[$];
    logic [2:0]  k_t [6] = '{CLS_SDP, CLS_DCP, CLS_CDP, CLS_CDP, CLS_BH_LOW, CLS_BH_HIGH};
    logic [7:0]  c_t [6] = '{8'h00, 8'h00, 8'h10, 8'h00, 8'h20, 8'h20};
    logic [2:0]  e_t [6] = '{CLS_SDP, CLS_DCP, CLS_CDP, CLS_DCP, CLS_BH_LOW, CLS_BH_HIGH};
    ucdp_ctrl #(.TICK_CYCLES(10), .PHASE_TICKS(2), .ATTN_TICKS(1)) dut_u (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .low_supply_lockout(lo), .high_supply_lockout(hi), .line_state(ls),
        .data_voltage_raw(raw), .dm_reflects_dp(refl), .high_current_dm(hcd), .supply_guard_closed(guard),
        .current_limit_on(limit), .path_one_on(p1), .path_two_on(p2), .data_voltage_seen(dvs),
        .attention_n(attn_n), .irq(irq)
    );
    ucdp_port_model port_u (
        .plugged(plugged), .over(over), .kind(kind), .noise_en(noise_en), .noise(noise),
        .low_supply_lockout(lo), .high_supply_lockout(hi), .line_state(ls), .data_voltage_raw(raw),
        .dm_reflects_dp(refl), .high_current_dm(hcd)
    );
    initial begin
        aclk = 1'h0;
        forever #2 aclk = ~aclk;
    end
    task check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task print_verdict;
        $display("checks=%0d mismatches=%0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task tmo;
        err_count++;
        print_verdict();
    endtask
    task wr(input logic [3:0] a, input logic [31:0] d);
        int n;
        bit got;
        got = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        for (n = 0; n < 100 && !got; n++) begin
            @(posedge aclk);
            if (awvalid && awready === 1'h1) awvalid <= 1'h0;
            if (wvalid && wready === 1'h1) wvalid <= 1'h0;
            got = (bvalid === 1'h1);
        end
        if (got) check({30'h0, bresp}, {30'h0, RESP_OKAY});
        bready <= 1'h0;
        if (!got) tmo();
    endtask
    task rd(input logic [3:0] a, input logic [31:0] d, input logic [31:0] m, input logic [1:0] r);
        int n;
        bit got;
        got = 0;
        note_q.push_back('{d, m, r});
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        for (n = 0; n < 100 && !got; n++) begin
            @(posedge aclk);
            if (arvalid && arready === 1'h1) arvalid <= 1'h0;
            got = (rvalid === 1'h1);
        end
        rready <= 1'h0;
        if (!got) tmo();
    endtask
    always @(posedge aclk) begin
        if (rvalid === 1'h1 && rready === 1'h1) begin
            cur = note_q.pop_front();
            check(rdata & cur.m, cur.d & cur.m);
            check({30'h0, rresp}, {30'h0, cur.r});
        end
    end
    task run_case(input int c);
        int w;
        plugged <= 1'h0;
        repeat (4) @(posedge aclk);
        check({27'h0, guard, p1, p2, irq, attn_n}, 32'h1);
        rd(OFF_STATUS, 32'h0, 32'hF0, RESP_OKAY);
        rd(OFF_CONFIG, 32'h0, 32'hFF, RESP_OKAY);
        kind <= k_t[c];
        plugged <= 1'h1;
        wr(OFF_CONFIG, {24'h0, c_t[c]});
        wr(OFF_IRQ_EN, 32'h1);
        check({30'h0, limit, p1 | p2}, 32'h2);
        for (w = 0; w < 400 && attn_n !== 1'h0; w++) @(posedge aclk);
        if (w == 400) tmo();
        repeat (2) @(posedge aclk);
        check({28'h0, p1, p2, limit, irq}, {28'h0, 1'h1, 1'h0, (c == 0), 1'h1});
        if (c == 1) begin
            for (w = 0; w < 100 && attn_n !== 1'h1; w++) @(posedge aclk);
            check({31'h0, w < 24}, 32'h1);
        end else begin
            rd(OFF_STATUS, {24'h0, e_t[c], 1'h1, (c == 0), 3'h0}, 32'hF8, RESP_OKAY);
            @(posedge aclk);
            check({31'h0, attn_n}, 32'h1);
        end
        wr(OFF_IRQ_STAT, 32'h3);
        @(posedge aclk);
        check({31'h0, irq}, 32'h0);
        if (c == 0) begin
            wr(OFF_CONFIG, 32'h1);
            repeat (2) @(posedge aclk);
            check({31'h0, limit}, 32'h0);
        end
        $display("case %0d done", c);
    endtask
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'h1;
        for (i = 0; i < 6; i++) run_case(i);
        wr(OFF_CONFIG, 32'h2);
        check({31'h0, guard}, 32'h0);
        wr(OFF_CONFIG, 32'h3);
        check({31'h0, guard}, 32'h1);
        wr(OFF_CONFIG, 32'h8);
        repeat (2) @(posedge aclk);
        check({30'h0, p1, p2}, 32'h1);
        wr(OFF_CONFIG, 32'hC);
        repeat (2) @(posedge aclk);
        check({30'h0, p1, p2}, 32'h2);
        wr(OFF_IRQ_EN, 32'h2);
        over <= 1'h1;
        repeat (3) @(posedge aclk);
        check({29'h0, guard, p1 | p2, irq}, 32'h1);
        rd(OFF_IRQ_STAT, 32'h2, 32'h2, RESP_OKAY);
        wr(OFF_IRQ_EN, 32'h0);
        check({31'h0, irq}, 32'h0);
        wr(OFF_IRQ_EN, 32'h2);
        check({31'h0, irq}, 32'h1);
        over <= 1'h0;
        wr(OFF_IRQ_STAT, 32'h2);
        @(posedge aclk);
        check({31'h0, irq}, 32'h0);
        rd(4'h2, 32'h0, 32'hFFFFFFFF, RESP_SLVERR);
        $display("lockout and register test done");
        wr(OFF_CONFIG, 32'h0);
        noise_en <= 1'h1;
        for (i = 0; i < 16; i++) begin
            noise <= 3'($random(seed));
            repeat (2) @(posedge aclk);
            check({31'h0, dvs}, {31'h0, noise[2] && noise[1:0] == 2'h0});
        end
        $display("line state test done");
        print_verdict();
    end
endmodule // tb_usb_charger_detect_protect_ctrl
`default_nettype wire
